// *** csg_counter.v ***
// One counter channel of a multi-channel timer, upper (special-gate) half of the mode map.
// Assumes an APB master on pclk; source and gate inputs synchronous to pclk.
`timescale 1ns/1ps
`include "csg_defines.vh"

// Function
// - Mode comes from gate field, special-gate, reload-source and repetition bits.
// - Repetition clear: counter disarms at sequence end; software re-arms each time.
// - Repetition set: counter stays armed through terminal counts; edge-gated modes then wait for the next gate edge.
// - Modes N, O, Q, R: gate edge captures count to Hold, then reloads Load.
// - Mode X: gate edge captures count to Hold, counting continues undisturbed.
// - Modes S, V: terminal count reloads Load if gate low, Hold if high.
// - Edge-gated modes start on gate edge and stop at next terminal count.
// - Count advances only on the active-going source transition.
// - Gate starts and captures respond only to the active-going gate transition; level gating and S/V reload select follow the gate level.
// - In terminal count the next source edge always counts; stops follow it.
module csg_counter #(
	parameter WIDTH = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire src_in,
	input wire gate_in,
	output reg tc_out,
	output reg armed_out
);

	// ==========================================
	// Declarations
	reg [15:0] mode_q;
	reg [WIDTH-1:0] load_q;
	reg [WIDTH-1:0] hold_q;
	reg [WIDTH-1:0] count_q;
	reg [WIDTH-1:0] count_d;
	reg [WIDTH-1:0] hold_d;
	reg armed_q;
	reg armed_d;
	reg tc_q;
	reg tc_d;
	reg run_q;
	reg run_d;
	reg mapped;
	reg [31:0] rd_mux;
	reg [WIDTH-1:0] reload_val;
	reg count_ok;
	reg two_tc_q;
	reg two_tc_d;

	wire wr_en;
	wire rd_setup;
	wire cmd_wr;
	wire reserved;
	wire repeat_en;
	wire level_gate;
	wire edge_start;
	wire retrig;
	wire capture_only;
	wire gate_reload;
	wire gate_low;
	wire src_low;
	wire src_edge;
	wire gate_act;
	wire gate_edge;
	wire gate_trig;
	wire mode_wr;
	wire load_wr;
	wire hold_wr;
	wire arm_cmd;
	wire disarm_cmd;
	wire load_cmd;
	wire gate_cap;
	wire two_tc_mode;

	// Unit step of the down counter
	localparam [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

	// ==========================================
	// Submodules
	csg_mode_dec u_dec (
		.mode(mode_q),
		.reserved(reserved),
		.repeat_en(repeat_en),
		.level_gate(level_gate),
		.edge_start(edge_start),
		.retrig(retrig),
		.capture_only(capture_only),
		.gate_reload(gate_reload),
		.gate_low(gate_low),
		.src_low(src_low)
	);

	csg_edge_det u_src (
		.pclk(pclk),
		.presetn(presetn),
		.sig_in(src_in),
		.active_low(src_low),
		.active(),
		.edge_pulse(src_edge)
	);

	csg_edge_det u_gate (
		.pclk(pclk),
		.presetn(presetn),
		.sig_in(gate_in),
		.active_low(gate_low),
		.active(gate_act),
		.edge_pulse(gate_edge)
	);

	// ==========================================
	// APB decode
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign cmd_wr = wr_en && (paddr == `CSG_OFF_CMD);
	assign pslverr = psel & penable & ~mapped;

	always @* begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			`CSG_OFF_MODE: rd_mux[15:0] = mode_q;
			`CSG_OFF_LOAD: rd_mux[WIDTH-1:0] = load_q;
			`CSG_OFF_HOLD: rd_mux[WIDTH-1:0] = hold_q;
			`CSG_OFF_COUNT: rd_mux[WIDTH-1:0] = count_q;
			`CSG_OFF_CMD: rd_mux = 32'h0000_0000;
			`CSG_OFF_STATUS: begin
				rd_mux[`CSG_ST_ARMED] = armed_q;
				rd_mux[`CSG_ST_TC] = tc_q;
				rd_mux[`CSG_ST_RUN] = run_q;
				rd_mux[`CSG_ST_RSVD] = reserved;
			end
			default: mapped = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rd_mux;
		end
	end

	// ==========================================
	// Software registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= `CSG_MODE_RST;
			load_q <= {WIDTH{1'b0}};
		end else if (wr_en) begin
			if (mode_wr) begin
				mode_q <= pwdata[15:0];
			end
			if (load_wr) begin
				load_q <= pwdata[WIDTH-1:0];
			end
		end
	end

	// ==========================================
	// Counting control
	// Gate edges only count as triggers while armed
	assign gate_trig = gate_edge & armed_q;

	// ==========================================
	// Command and capture strobes
	assign mode_wr = wr_en && (paddr == `CSG_OFF_MODE);
	assign load_wr = wr_en && (paddr == `CSG_OFF_LOAD);
	assign hold_wr = wr_en && (paddr == `CSG_OFF_HOLD);

	// A command write may set several bits; arm wins over disarm
	assign arm_cmd = cmd_wr & pwdata[`CSG_CMD_ARM];
	assign disarm_cmd = cmd_wr & pwdata[`CSG_CMD_DISARM];
	assign load_cmd = cmd_wr & pwdata[`CSG_CMD_LOAD];
	// A gate edge in terminal count or in a reserved mode captures nothing
	assign gate_cap = gate_trig && !reserved && !tc_q && (retrig || capture_only);
	// Gate-selected reload without repetition runs two terminal counts before disarming
	assign two_tc_mode = gate_reload && !repeat_en;

	always @* begin
		// Reload source on leaving terminal count
		if (gate_reload && gate_act) begin
			reload_val = hold_q;
		end else begin
			reload_val = load_q;
		end
		// Qualification of a source edge outside terminal count
		count_ok = armed_q && !reserved;
		if (level_gate && !gate_act) begin
			count_ok = 1'b0;
		end
		if (edge_start && !run_q) begin
			count_ok = 1'b0;
		end
	end

	// ==========================================
	// Next state
	always @* begin
		count_d = count_q;
		hold_d = hold_q;
		armed_d = armed_q;
		tc_d = tc_q;
		run_d = run_q;
		two_tc_d = two_tc_q;
		if (src_edge && tc_q) begin
			// Terminal count always takes the edge, stop and disarm follow
			count_d = reload_val;
			tc_d = 1'b0;
			if (two_tc_mode && !two_tc_q) begin
				// First of the two terminal counts keeps the arm
				two_tc_d = 1'b1;
			end else if (!repeat_en) begin
				armed_d = 1'b0;
				two_tc_d = 1'b0;
			end
			if (edge_start) begin
				run_d = 1'b0;
			end
		end else if (src_edge && count_ok) begin
			// Repetition keeps the arm through every terminal count
			if (count_q == CNT_ONE) begin
				count_d = {WIDTH{1'b0}};
				tc_d = 1'b1;
			end else begin
				count_d = count_q - CNT_ONE;
			end
		end
		// Gate trigger: start, retrigger or capture
		if (gate_trig && !reserved && !tc_q) begin
			if (edge_start) begin
				run_d = 1'b1;
			end
			if (retrig) begin
				hold_d = count_q;
				count_d = load_q;
				tc_d = 1'b0;
			end else if (capture_only) begin
				hold_d = count_q;
			end
		end
		// Commands act last so that they override the events above
		if (mode_wr) begin
			two_tc_d = 1'b0;
		end
		if (load_cmd) begin
			count_d = load_q;
			tc_d = 1'b0;
		end
		if (disarm_cmd) begin
			armed_d = 1'b0;
			run_d = 1'b0;
			two_tc_d = 1'b0;
		end
		if (arm_cmd) begin
			armed_d = 1'b1;
			two_tc_d = 1'b0;
		end
		// Software write to Hold yields to a gate capture in the same cycle
		if (hold_wr && !gate_cap) begin
			hold_d = pwdata[WIDTH-1:0];
		end
	end

	// ==========================================
	// State registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= {WIDTH{1'b0}};
			hold_q <= {WIDTH{1'b0}};
			armed_q <= 1'b0;
			tc_q <= 1'b0;
			run_q <= 1'b0;
			two_tc_q <= 1'b0;
			tc_out <= 1'b0;
			armed_out <= 1'b0;
		end else begin
			count_q <= count_d;
			hold_q <= hold_d;
			armed_q <= armed_d;
			tc_q <= tc_d;
			run_q <= run_d;
			two_tc_q <= two_tc_d;
			// Outputs are registered copies of the next state
			tc_out <= tc_d;
			armed_out <= armed_d;
		end
	end

endmodule

// *** csg_defines.vh ***
// Constants for the special-gate counter channel: register map, mode fields, command bits.
// Assumes inclusion by csg_counter.v, csg_mode_dec.v and csg_edge_det.v.
`ifndef CSG_DEFINES_VH
`define CSG_DEFINES_VH

// ==========================================
// Register byte offsets
`define CSG_OFF_MODE 8'h00
`define CSG_OFF_LOAD 8'h04
`define CSG_OFF_HOLD 8'h08
`define CSG_OFF_COUNT 8'h0c
`define CSG_OFF_CMD 8'h10
`define CSG_OFF_STATUS 8'h14

// ==========================================
// Mode register fields
`define CSG_GATE_HI 15
`define CSG_GATE_LO 13
`define CSG_SRC_FALL_BIT 12
`define CSG_SPECIAL_BIT 7
`define CSG_RELOAD_BIT 6
`define CSG_REPEAT_BIT 5
`define CSG_MODE_RST 16'h0080

// ==========================================
// Gate control codes
`define CSG_GC_NONE 3'h0
`define CSG_GC_LVL_HI 3'h4
`define CSG_GC_LVL_LO 3'h5
`define CSG_GC_EDGE_RISE 3'h6
`define CSG_GC_EDGE_FALL 3'h7

// ==========================================
// Command register bits
`define CSG_CMD_ARM 0
`define CSG_CMD_DISARM 1
`define CSG_CMD_LOAD 2

// ==========================================
// Status register bits
`define CSG_ST_ARMED 0
`define CSG_ST_TC 1
`define CSG_ST_RUN 2
`define CSG_ST_RSVD 3

`endif

// *** csg_edge_det.v ***
// Active-going edge and active level of one input with selectable polarity.
// Assumes the input is synchronous to pclk.
`timescale 1ns/1ps
`include "csg_defines.vh"

module csg_edge_det (
	input wire pclk,
	input wire presetn,
	input wire sig_in,
	input wire active_low,
	output wire active,
	output wire edge_pulse
);

	reg prev_q;

	assign active = sig_in ^ active_low;
	assign edge_pulse = active & ~(prev_q ^ active_low);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sig_in;
		end
	end

endmodule

// *** csg_far_end.sv ***
// Far-side model: drives the count source and the gate input.
// Assumes callers step it from code synchronous to pclk.
`timescale 1ns/1ps

module csg_far_end (
	input wire pclk,
	output reg src_in,
	output reg gate_in
);
	initial begin
		src_in = 1'b0;
		gate_in = 1'b0;
	end
	// ==========================================
	// Stimulus tasks: each source level held w cycles, each gate level 2 cycles
	task pulse(input integer w);
		@(posedge pclk);
		src_in <= 1'b1;
		repeat (w) @(posedge pclk);
		src_in <= 1'b0;
		repeat (w) @(posedge pclk);
	endtask
	task set_gate(input g);
		@(posedge pclk);
		gate_in <= g;
		repeat (2) @(posedge pclk);
	endtask
endmodule

// *** csg_mode_dec.v ***
// Decodes the mode bits into the behaviour controls of the counter channel.
// Assumes the mode word is held stable in a register.
`timescale 1ns/1ps
`include "csg_defines.vh"

module csg_mode_dec (
	input wire [15:0] mode,
	output reg reserved,
	output reg repeat_en,
	output reg level_gate,
	output reg edge_start,
	output reg retrig,
	output reg capture_only,
	output reg gate_reload,
	output reg gate_low,
	output reg src_low
);

	reg [2:0] gc;
	reg special;
	reg reload_src;
	reg has_level;
	reg has_edge;

	// ==========================================
	// Mode decode
	always @* begin
		gc = mode[`CSG_GATE_HI:`CSG_GATE_LO];
		special = mode[`CSG_SPECIAL_BIT];
		reload_src = mode[`CSG_RELOAD_BIT];
		repeat_en = mode[`CSG_REPEAT_BIT];
		src_low = mode[`CSG_SRC_FALL_BIT];
		// Unlisted nonzero codes act as active-high level gating
		has_edge = (gc == `CSG_GC_EDGE_RISE) || (gc == `CSG_GC_EDGE_FALL);
		has_level = (gc != `CSG_GC_NONE) && !has_edge;
		gate_low = (gc == `CSG_GC_LVL_LO) || (gc == `CSG_GC_EDGE_FALL);
		level_gate = has_level;
		edge_start = has_edge;
		retrig = special && !reload_src && (gc != `CSG_GC_NONE);
		capture_only = special && reload_src && repeat_en && has_edge;
		gate_reload = special && reload_src && (gc == `CSG_GC_NONE);
		// Codes M, P, T, U and W
		reserved = special && ((gc == `CSG_GC_NONE && !reload_src) || (reload_src && has_level)
			|| (reload_src && !repeat_en && has_edge));
	end

endmodule

// *** csg_properties.sv ***
// Checker for the special-gate counter: APB, arming and terminal count.
// Assumes inputs synchronous to pclk; bound to every csg_counter.
`timescale 1ns/1ps

module csg_properties (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire src_in,
	input wire tc_out,
	input wire armed_out
);
	reg fall_q;
	reg src_q;
	wire wr = psel && penable && pwrite;
	wire arm_w = wr && paddr == 8'h10 && pwdata[0];
	wire act = src_in ^ fall_q;
	wire sedge = act && !(src_q ^ fall_q);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fall_q <= 1'b0;
			src_q <= 1'b0;
		end else begin
			src_q <= src_in;
			if (wr && paddr == 8'h00)
				fall_q <= pwdata[12];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// Properties
	tc_exit_a: assert property (tc_out && sedge && !wr |=> !tc_out)
		else $error("tc kept after edge");
	tc_hold_a: assert property (tc_out && !sedge && !wr |=> tc_out)
		else $error("tc lost without edge");
	tc_cause_a: assert property ($rose(tc_out) |-> $past(sedge))
		else $error("tc without edge");
	arm_cmd_a: assert property (arm_w |=> armed_out)
		else $error("arm ignored");
	self_arm_a: assert property ($rose(armed_out) |-> $past(arm_w))
		else $error("arm without command");
	disarm_tc_a: assert property ($fell(armed_out) && !$past(wr) |-> $past(tc_out))
		else $error("disarm outside tc");
	bad_addr_a: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
		else $error("no slave error");
	ready_on_a: assert property (psel |-> pready)
		else $error("pready low");
	cover property (tc_out && sedge);
	cover property ($fell(armed_out));
	cover property (arm_w);
endmodule

bind csg_counter csg_properties u_csg_properties (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .src_in, .tc_out, .armed_out);

// *** testbench.sv ***
// Bench for csg_counter: walks nine non-reserved special-gate modes against an integer model.
// Assumes csg_far_end drives source and gate; checker bound separately.
`timescale 1ns/1ps

module testbench;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, src_in, gate_in, tc_out, armed_out;
	reg [31:0] rdat, rnd;
	reg rerr;
	reg [31:0] seed = 32'h1a059f59;
	integer miscompares = 0;
	integer cmp_count = 0;
	integer cyc = 0;
	integer mc, ml, mh, mtc, marm, mrun, mgc, mrel, mrep, mtwo, i, k;
	reg mpol;
	reg [15:0] modes [0:8];
	csg_counter #(.WIDTH(16)) u_csg_counter (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .src_in, .gate_in, .tc_out, .armed_out);
	csg_far_end u_far (.pclk, .src_in, .gate_in);
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			end_of_test;
		end
	end
	// ==========================================
	// Bus, compare and model tasks
	task chk(input [31:0] got, input [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input [7:0] a, input [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task gate(input g);
		if ((g ^ mpol) && !(gate_in ^ mpol) && marm && !mtc && mgc) begin
			if (mgc == 2)
				mrun = 1;
			mh = mc;
			if (!mrel)
				mc = ml;
		end
		u_far.set_gate(g);
	endtask
	task src(input integer w);
		if (mtc) begin
			mc = (mrel && !mgc && gate_in) ? mh : ml;
			mtc = 0;
			mrun = 0;
			if (!mrep && mrel && !mgc && !mtwo)
				mtwo = 1;
			else if (!mrep) begin
				marm = 0;
				mtwo = 0;
			end
		end else if (marm && (mgc == 0 || (mgc == 1 ? (gate_in ^ mpol) : mrun))) begin
			mc = mc - 1;
			mtc = (mc == 0);
		end
		u_far.pulse(w);
	endtask
	task end_of_test;
		$display("comparisons %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		modes[0] = 16'h00c0;
		modes[1] = 16'h00e0;
		modes[2] = 16'h8080;
		modes[3] = 16'hc080;
		modes[4] = 16'h80a0;
		modes[5] = 16'hc0a0;
		modes[6] = 16'hc0e0;
		modes[7] = 16'ha080;
		modes[8] = 16'hf0a0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rchk(8'h00, 32'h80);
		rchk(8'h14, 32'h8);
		rchk(8'h18, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		for (i = 0; i < 9; i = i + 1) begin
			mgc = modes[i][15] ? (modes[i][14] ? 2 : 1) : 0;
			mrel = modes[i][6];
			mpol = modes[i][15] & modes[i][13];
			mrep = modes[i][5];
			ml = 2 + {$random(seed)} % 3;
			mh = 2 + {$random(seed)} % 3;
			mc = ml;
			mtc = 0;
			marm = 1;
			mtwo = 0;
			mrun = 0;
			u_far.set_gate(1'b0);
			apb(1'b1, 8'h00, {16'h0, modes[i]});
			apb(1'b1, 8'h04, ml);
			apb(1'b1, 8'h08, mh);
			apb(1'b1, 8'h10, 32'h6);
			apb(1'b1, 8'h10, 32'h1);
			for (k = 0; k < 14; k = k + 1) begin
				rnd = $random(seed);
				gate(rnd[0]);
				src(2 + rnd[1]);
				rchk(8'h0c, mc);
				rchk(8'h08, mh);
				chk({30'h0, tc_out, armed_out}, {mtc[0], marm[0]});
				rchk(8'h14, {29'h0, mrun[0], mtc[0], marm[0]});
			end
		end
		end_of_test;
	end
endmodule
